//--- dv/cdsg_checker.sv
/*
  port checker for cdsg_top, bound below.
  assumes pin clocks far slower than clk_sys and a 3-edge pin path.
*/
`default_nettype none
`include "cdsg_map.svh"
module cdsg_checker (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic pdiv_clk_in,
  input wire logic pdiv_rst_in,
  input wire cdsg_pkg::cdsg_pdiv_e pdiv_ratio,
  input wire logic edge_rst_in,
  input wire logic dsm_in0,
  input wire logic dsm_in1,
  input wire cdsg_pkg::cdsg_dsm_cfg_s dsm_cfg,
  input wire logic [`CDSG_NEXT-1:0] center_clock_mux_src,
  input wire logic [`CDSG_NTRUNK*`CDSG_TSEL_W-1:0] trunk_sel,
  input wire logic [`CDSG_NTRUNK-1:0] trunk_en,
  input wire logic pdiv_out,
  input wire logic edge_out,
  input wire logic dsm_out,
  input wire logic [`CDSG_NTRUNK-1:0] trunk_out,
  input wire cdsg_pkg::cdsg_dll_s dll_status
);
  logic [3:0] st;
  logic [5:0] dis;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // settle count keeps $past away from reset history
  always_ff @(posedge clk_sys) st <= rst ? 4'h0 : (st == 4'h8 ? st : st + 4'h1);
  always_ff @(posedge clk_sys) begin
    dis <= (rst || trunk_en[0]) ? 6'h00 : (dis == 6'h3f ? dis : dis + 6'h01);
  end
  sequence s_byp;
    (st == 4'h8 && pdiv_ratio == cdsg_pkg::PDIV_BYPASS && !pdiv_rst_in) [*6];
  endsequence
  sequence s_plain;
    (st == 4'h8 && !dsm_cfg.glitchless && (dsm_cfg.sel || !dsm_cfg.div_in0)
      && $stable(dsm_cfg)) [*6];
  endsequence
  property p_pdiv_rst; pdiv_rst_in [*4] |-> !pdiv_out; endproperty
  property p_edge_rst; edge_rst_in [*4] |-> !edge_out; endproperty
  property p_bypass; s_byp |-> pdiv_out == $past(pdiv_clk_in, 3); endproperty
  property p_plain; s_plain |-> dsm_out == $past(dsm_cfg.sel ? dsm_in1 : dsm_in0, 3); endproperty
  property p_glitch; dsm_cfg.glitchless && $rose(dsm_out) |=> dsm_out [*2]; endproperty
  property p_off; dis > 6'h1e |-> !trunk_out[0]; endproperty
  property p_t0;
    (st == 4'h8 && trunk_en[0] && trunk_sel[5:0] == 6'h02) [*8]
      |-> trunk_out[0] == $past(center_clock_mux_src[0], 3);
  endproperty
  property p_t15;
    (st == 4'h8 && trunk_en[15] && trunk_sel[95:90] == 6'h3f) [*8]
      |-> trunk_out[15] == $past(center_clock_mux_src[61], 3);
  endproperty
  property p_dll; dll_status.valid |=> dll_status.valid; endproperty
  a_pdiv_rst: assert property (p_pdiv_rst) else $error("primary out high in reset");
  a_edge_rst: assert property (p_edge_rst) else $error("edge out high in reset");
  a_bypass: assert property (p_bypass) else $error("bypass mismatch");
  a_plain: assert property (p_plain) else $error("plain select mismatch");
  a_glitch: assert property (p_glitch) else $error("short select pulse");
  a_off: assert property (p_off) else $error("disabled trunk toggles");
  a_t0: assert property (p_t0) else $error("trunk 0 mismatch");
  a_t15: assert property (p_t15) else $error("trunk 15 mismatch");
  a_dll: assert property (p_dll) else $error("loop valid dropped");
endmodule : cdsg_checker
bind cdsg_top cdsg_checker cdsg_checker_inst (.*);
`default_nettype wire

//--- dv/cdsg_fabric.sv
/*
  fabric-side clock sources: sixteen free-running clocks, clock k
  toggling every k+2 cycles of clk_sys.
  assumes the bench supplies clk_sys and rst.
*/
`default_nettype none
module cdsg_fabric (
  input wire logic clk_sys,
  input wire logic rst,
  output logic [15:0] clks
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [4:0] cnt [16];
  // never stopped: a glitchless select would stall on a clock stopped high
  always @(posedge clk_sys) begin
    for (int k = 0; k < 16; k++) begin
      if (rst || cnt[k] == 5'(k + 1)) begin
        cnt[k] <= 5'h00;
        clks[k] <= rst ? 1'b0 : ~clks[k];
      end else begin
        cnt[k] <= cnt[k] + 5'h01;
      end
    end
  end
endmodule : cdsg_fabric
`default_nettype wire

//--- dv/testbench.sv
/*
  bench for cdsg_top: the fabric model makes the clocks, tasks drive
  controls and time the outputs at the falling edge.
  assumes the design package and header are compiled first.
*/
`default_nettype none
`include "cdsg_map.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys, rst, prst, erst, po, eo, so, sko, sto;
  logic [15:0] clks, h1, h2, h3, ten, tout, p;
  cdsg_pkg::cdsg_pdiv_e pr;
  cdsg_pkg::cdsg_ediv_e er;
  cdsg_pkg::cdsg_dsm_cfg_s cfg;
  cdsg_pkg::cdsg_dll_s dll;
  logic [3:0] esel, pick;
  logic [95:0] tsel;
  int err_count = 0;
  int tests_run = 0;
  int cyc = 0;
  wire probe = pick == 0 ? po : pick == 1 ? eo : pick == 2 ? so : pick == 3 ? sko : sto;
  cdsg_fabric cdsg_fabric_inst (.clk_sys(clk_sys), .rst(rst), .clks(clks));
  cdsg_top cdsg_top_inst (.clk_sys(clk_sys), .rst(rst), .pdiv_clk_in(clks[2]),
    .pdiv_rst_in(prst), .pdiv_ratio(pr), .edge_pin(clks[6]), .pll_out(clks[12:7]),
    .edge_int(clks[15]), .edge_sel(esel), .edge_rst_in(erst), .edge_ratio(er),
    .dsm_in0(clks[1]), .dsm_in1(clks[3]), .dsm_cfg(cfg),
    .center_clock_mux_src({clks[13:0], clks, clks, clks}), .trunk_sel(tsel), .trunk_en(ten),
    .dll_ref_in(clks[6]), .strobe_in(clks[6]), .pdiv_out(po), .edge_out(eo),
    .dsm_out(so), .trunk_out(tout), .dll_status(dll), .slave_clk_out(sko), .strobe_out(sto));
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    {h3, h2, h1} <= {h2, h1, clks};
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      err_count++;
      final_report;
    end
  end
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: saw %0h want %0h", $time, seen, exp);
    end
  endtask : chk
  task per(output logic [15:0] n);
    logic b;
    int k;
    b = probe;
    n = 0;
    k = 0;
    // first high phase after a divider restart may be short, so skip it
    for (int i = 0; i < 5000 && k < 3; i++) begin
      @(negedge clk_sys);
      if (k == 2) n++;
      if (probe && !b) k++;
      b = probe;
    end
  endtask : per
  // cycles from a rise of clks[idx]^inv to the next rise of probe
  task lag(input int idx, input logic inv, output logic [15:0] n);
    logic a, b;
    int k;
    a = clks[idx] ^ inv;
    b = probe;
    n = 0;
    k = 0;
    for (int i = 0; i < 400 && k < 2; i++) begin
      @(negedge clk_sys);
      if (k == 1) n++;
      if (k == 0 && (clks[idx] ^ inv) && !a) k = 1;
      else if (k == 1 && probe && !b) k = 2;
      a = clks[idx] ^ inv;
      b = probe;
    end
  endtask : lag
  task t_pdiv;
    pick = 0;
    for (int r = 0; r < 8; r++) begin
      @(posedge clk_sys);
      pr <= cdsg_pkg::cdsg_pdiv_e'(r);
      prst <= 1'b1;
      repeat (4) @(posedge clk_sys);
      prst <= 1'b0;
      per(p);
      chk(p, 16'h0008 << r);
    end
  endtask : t_pdiv
  task t_rst;
    @(posedge clk_sys);
    pr <= cdsg_pkg::PDIV_2;
    esel <= 4'h0;
    er <= cdsg_pkg::EDIV_2;
    prst <= 1'b1;
    erst <= 1'b1;
    repeat (4) @(posedge clk_sys);
    repeat (40) begin
      @(negedge clk_sys);
      chk({14'h0000, po, eo}, 16'h0000);
    end
    @(posedge clks[2]);
    @(posedge clk_sys);
    prst <= 1'b0;
    lag(2, 1'b0, p);
    chk(p, 16'h0003);
    pick = 1;
    @(posedge clks[6]);
    @(posedge clk_sys);
    erst <= 1'b0;
    lag(6, 1'b1, p);
    chk(p, 16'h0003);
  endtask : t_rst
  task t_edge;
    logic [15:0] want;
    pick = 1;
    for (int i = 0; i < 14; i++) begin
      @(posedge clk_sys);
      esel <= i < 10 ? (i == 9 ? 4'hf : 4'(i)) : 4'h0;
      er <= i < 10 ? cdsg_pkg::EDIV_2 : cdsg_pkg::cdsg_ediv_e'(i - 10);
      erst <= 1'b1;
      repeat (4) @(posedge clk_sys);
      erst <= 1'b0;
      per(p);
      want = 16'(8 * (i == 10 ? 4 : i == 11 ? 7 : i == 12 ? 8 : 10));
      if (i < 10) begin
        want = 16'(4 * (i < 2 ? 8 : i < 8 ? i + 7 : 17));
      end
      chk(p, want);
    end
  endtask : t_edge
  task t_dsm;
    pick = 2;
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_sys);
      cfg <= '{sel: i[0], glitchless: i[1], div_in0: !i[1]};
      repeat (40) @(posedge clk_sys);
      if (i < 2) begin
        per(p);
        chk(p, i == 0 ? 16'h0010 : 16'h000a);
      end
      else repeat (12) begin
        @(negedge clk_sys);
        chk({15'h0000, so}, {15'h0000, h3[i == 2 ? 1 : 3]});
      end
    end
  endtask : t_dsm
  task t_trunk;
    for (int ph = 0; ph < 3; ph++) begin
      @(posedge clk_sys);
      ten <= ph == 1 ? 16'h0000 : 16'hffff;
      // gate moves only in a low phase; slow sources delay it either way
      repeat (ph == 1 ? 100 : 40) @(posedge clk_sys);
      repeat (12) begin
        @(negedge clk_sys);
        if (ph == 1) begin
          chk(tout, 16'h0000);
        end else begin
          chk({14'h0000, tout[15], tout[0]}, {14'h0000, h3[13], h3[0]});
        end
      end
    end
  endtask : t_trunk
  task t_dll;
    for (int i = 0; i < 200 && dll.valid !== 1'b1; i++) @(negedge clk_sys);
    chk({6'h00, dll}, {6'h00, 9'h004, 1'b1});
    pick = 3;
    lag(6, 1'b0, p);
    chk(p, 16'h0007);
    pick = 4;
    lag(6, 1'b0, p);
    chk(p, 16'h0007);
  endtask : t_dll
  task final_report;
    if (err_count == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : final_report
  initial begin
    rst = 1'b1;
    prst = 1'b0;
    erst = 1'b0;
    pr = cdsg_pkg::PDIV_BYPASS;
    er = cdsg_pkg::EDIV_2;
    esel = 4'h0;
    cfg = '0;
    tsel = {{13{6'h3f}}, 6'h00, 6'h01, 6'h02};
    ten = 16'hffff;
    pick = 4'h0;
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (4) @(posedge clk_sys);
    t_pdiv;
    t_rst;
    t_edge;
    t_dsm;
    t_trunk;
    t_dll;
    final_report;
  end
endmodule : testbench
`default_nettype wire

//--- logic/cdsg_map.svh
/*
  constants for the clock divide, select and gate block.
  assumes inclusion by the package, the top module, the checker and the bench.
*/
`ifndef CDSG_MAP_SVH
`define CDSG_MAP_SVH
`define CDSG_CLK_NS 20
`define CDSG_ASYNC_W 77
`define CDSG_B_PCLK 0
`define CDSG_B_PRST 1
`define CDSG_B_EPIN 2
`define CDSG_B_PLL 3
`define CDSG_B_EINT 9
`define CDSG_B_ERST 10
`define CDSG_B_DIN0 11
`define CDSG_B_DIN1 12
`define CDSG_B_DREF 13
`define CDSG_B_STRB 14
`define CDSG_B_SRC 15
`define CDSG_NPLL 6
`define CDSG_NEXT 62
`define CDSG_NSRC 64
`define CDSG_NTRUNK 16
`define CDSG_TSEL_W 6
`define CDSG_PDCNT_W 7
`define CDSG_EDIV2_HC 4'h4
`define CDSG_EDIV3P5_HC 4'h7
`define CDSG_EDIV4_HC 4'h8
`define CDSG_EDIV5_HC 4'ha
`define CDSG_ESEL_PIN 4'h0
`define CDSG_ESEL_DLY 4'h1
`define CDSG_ESEL_PLL0 4'h2
`define CDSG_ESEL_PLL5 4'h7
`define CDSG_ESEL_INT 4'h8
`define CDSG_CODE_W 9
`define CDSG_CODE_MAX 9'h1ff
`define CDSG_PER_W 11
`define CDSG_PER_MAX 11'h7ff
`define CDSG_DLY_DEPTH 512
`endif

//--- logic/cdsg_pkg.sv
/*
  types for the clock divide, select and gate block.
  assumes cdsg_map.svh is on the include path.
*/
`default_nettype none
`include "cdsg_map.svh"
package cdsg_pkg;
  typedef enum logic [2:0] {
    PDIV_BYPASS = 3'h0, PDIV_2 = 3'h1, PDIV_4 = 3'h2, PDIV_8 = 3'h3,
    PDIV_16 = 3'h4, PDIV_32 = 3'h5, PDIV_64 = 3'h6, PDIV_128 = 3'h7
  } cdsg_pdiv_e;
  typedef enum logic [1:0] {
    EDIV_2 = 2'h0, EDIV_3P5 = 2'h1, EDIV_4 = 2'h2, EDIV_5 = 2'h3
  } cdsg_ediv_e;
  typedef enum logic [1:0] {
    SEL_RUN = 2'h0, SEL_WAIT_OLD = 2'h1, SEL_WAIT_NEW = 2'h2
  } cdsg_sel_state_e;
  typedef struct packed {
    logic sel;
    logic glitchless;
    logic div_in0;
  } cdsg_dsm_cfg_s;
  typedef struct packed {
    logic [`CDSG_CODE_W-1:0] code;
    logic valid;
  } cdsg_dll_s;
endpackage : cdsg_pkg
`default_nettype wire

//--- logic/cdsg_top.sv
/*
  clock dividers, dynamic select mux, per-trunk clock gates, center mux
  and master delay loop with its two slave delays, all modelled as
  sampled waveforms on clk_sys.
  assumes every clock and pin input is asynchronous and much slower
  than clk_sys; fabric controls are on clk_sys.
*/
//
// Behaviour
// - primary divider divides by 2..128 in powers of two, or bypasses
// - divider resets are asynchronous controls and force divider outputs low
// - divided output starts on the next input cycle after reset release
// - edge divider divides its edge clock by 2, 3.5, 4 or 5
// - edge divider phase is fixed by the moment its reset releases
// - select mux switches between two clocks, glitchless or plain by mode
// - primary divider optionally feeds select input 0; input 1 never divided
// - center mux routes any of 64 sources onto each of 16 trunks
// - a disabled trunk is held static low
// - trunk gating is glitchless and adds no latency over ungated trunks
// - edge source is pin, delayed pin, one of six pll outputs or internal
// - master loop makes a 9-bit quarter-period code and distributes it
// - slave clock delay shifts its clock by the distributed code
// - strobe delay buffer delays the strobe by the distributed code
`default_nettype none
`include "cdsg_map.svh"
module cdsg_top (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic pdiv_clk_in,
  input wire logic pdiv_rst_in,
  input wire cdsg_pkg::cdsg_pdiv_e pdiv_ratio,
  input wire logic edge_pin,
  input wire logic [`CDSG_NPLL-1:0] pll_out,
  input wire logic edge_int,
  input wire logic [3:0] edge_sel,
  input wire logic edge_rst_in,
  input wire cdsg_pkg::cdsg_ediv_e edge_ratio,
  input wire logic dsm_in0,
  input wire logic dsm_in1,
  input wire cdsg_pkg::cdsg_dsm_cfg_s dsm_cfg,
  input wire logic [`CDSG_NEXT-1:0] center_clock_mux_src,
  input wire logic [`CDSG_NTRUNK*`CDSG_TSEL_W-1:0] trunk_sel,
  input wire logic [`CDSG_NTRUNK-1:0] trunk_en,
  input wire logic dll_ref_in,
  input wire logic strobe_in,
  output logic pdiv_out,
  output logic edge_out,
  output logic dsm_out,
  output logic [`CDSG_NTRUNK-1:0] trunk_out,
  output cdsg_pkg::cdsg_dll_s dll_status,
  output logic slave_clk_out,
  output logic strobe_out
);

  function automatic logic edge_pick(
    input logic [3:0] s,
    input logic pin,
    input logic dly,
    input logic [`CDSG_NPLL-1:0] pll,
    input logic intn
  );
    logic r;
    r = intn;
    case (s)
      `CDSG_ESEL_PIN: r = pin;
      `CDSG_ESEL_DLY: r = dly;
      `CDSG_ESEL_INT: r = intn;
      default: begin
        if (s >= `CDSG_ESEL_PLL0 && s <= `CDSG_ESEL_PLL5) begin
          r = pll[3'(s - `CDSG_ESEL_PLL0)];
        end
      end
    endcase
    return r;
  endfunction : edge_pick

  function automatic logic [3:0] ediv_halves(input cdsg_pkg::cdsg_ediv_e m);
    logic [3:0] r;
    case (m)
      cdsg_pkg::EDIV_2: r = `CDSG_EDIV2_HC;
      cdsg_pkg::EDIV_3P5: r = `CDSG_EDIV3P5_HC;
      cdsg_pkg::EDIV_4: r = `CDSG_EDIV4_HC;
      default: r = `CDSG_EDIV5_HC;
    endcase
    return r;
  endfunction : ediv_halves

  // two-stage synchroniser for every pin, then one extra stage for edges
  logic [`CDSG_ASYNC_W-1:0] raw_in;
  logic [`CDSG_ASYNC_W-1:0] meta;
  logic [`CDSG_ASYNC_W-1:0] samp;
  logic [`CDSG_ASYNC_W-1:0] samp_d;
  assign raw_in = {center_clock_mux_src, strobe_in, dll_ref_in, dsm_in1, dsm_in0, edge_rst_in,
                   edge_int, pll_out, edge_pin, pdiv_rst_in, pdiv_clk_in};

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      meta <= '0;
      samp <= '0;
      samp_d <= '0;
    end else begin
      meta <= raw_in;
      samp <= meta;
      samp_d <= samp;
    end
  end

  // primary divider
  logic [`CDSG_PDCNT_W-1:0] pdiv_cnt;
  logic [`CDSG_PDCNT_W-1:0] next_pdiv_cnt;
  logic next_pdiv_out;
  logic pclk_rise;

  always_comb begin
    pclk_rise = samp[`CDSG_B_PCLK] & ~samp_d[`CDSG_B_PCLK];
    next_pdiv_cnt = pdiv_cnt;
    next_pdiv_out = pdiv_out;
    if (samp[`CDSG_B_PRST]) begin
      next_pdiv_cnt = '0;
      next_pdiv_out = 1'b0;
    end else if (pdiv_ratio == cdsg_pkg::PDIV_BYPASS) begin
      next_pdiv_out = samp[`CDSG_B_PCLK];
    end else if (pclk_rise) begin
      // count restarts from zero, so the first rise after release starts it
      next_pdiv_cnt = pdiv_cnt + 7'h01;
      next_pdiv_out = next_pdiv_cnt[3'(pdiv_ratio - 3'h1)];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pdiv_cnt <= '0;
      pdiv_out <= 1'b0;
    end else begin
      pdiv_cnt <= next_pdiv_cnt;
      pdiv_out <= next_pdiv_out;
    end
  end

  // edge divider: counts half periods so the 3.5 ratio needs no second edge
  logic edge_src;
  logic edge_src_q;
  logic [3:0] ediv_cnt;
  logic [3:0] next_ediv_cnt;
  logic next_edge_out;
  logic [3:0] ediv_per;

  always_comb begin
    edge_src = edge_pick(edge_sel, samp[`CDSG_B_EPIN], slave_clk_out,
                         samp[`CDSG_B_PLL +: `CDSG_NPLL], samp[`CDSG_B_EINT]);
    ediv_per = ediv_halves(edge_ratio);
    next_ediv_cnt = ediv_cnt;
    next_edge_out = edge_out;
    if (samp[`CDSG_B_ERST]) begin
      next_ediv_cnt = '0;
      next_edge_out = 1'b0;
    end else if (edge_src != edge_src_q) begin
      // phase counted from release, hence fixed to it
      next_ediv_cnt = (ediv_cnt >= ediv_per - 4'h1) ? 4'h0 : ediv_cnt + 4'h1;
      next_edge_out = (next_ediv_cnt < ((ediv_per + 4'h1) >> 1));
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      edge_src_q <= 1'b0;
      ediv_cnt <= '0;
      edge_out <= 1'b0;
    end else begin
      edge_src_q <= edge_src;
      ediv_cnt <= next_ediv_cnt;
      edge_out <= next_edge_out;
    end
  end

  // dynamic select mux
  cdsg_pkg::cdsg_sel_state_e sel_state;
  cdsg_pkg::cdsg_sel_state_e next_sel_state;
  logic sel_cur;
  logic next_sel_cur;
  logic next_dsm_out;
  logic dsm_a;
  logic dsm_b;
  logic cur_clk;

  always_comb begin
    dsm_a = dsm_cfg.div_in0 ? pdiv_out : samp[`CDSG_B_DIN0];
    dsm_b = samp[`CDSG_B_DIN1];
    cur_clk = sel_cur ? dsm_b : dsm_a;
    next_sel_state = sel_state;
    next_sel_cur = sel_cur;
    next_dsm_out = cur_clk;
    if (!dsm_cfg.glitchless) begin
      // plain mode follows the select at once; stopped clocks are fine
      next_sel_state = cdsg_pkg::SEL_RUN;
      next_sel_cur = dsm_cfg.sel;
      next_dsm_out = dsm_cfg.sel ? dsm_b : dsm_a;
    end else begin
      // hangs in a wait state if the awaited clock has stopped high
      case (sel_state)
        cdsg_pkg::SEL_RUN: begin
          if (dsm_cfg.sel != sel_cur) begin
            next_sel_state = cdsg_pkg::SEL_WAIT_OLD;
          end
        end
        cdsg_pkg::SEL_WAIT_OLD: begin
          if (!cur_clk) begin
            next_sel_state = cdsg_pkg::SEL_WAIT_NEW;
            next_sel_cur = ~sel_cur;
            next_dsm_out = 1'b0;
          end
        end
        cdsg_pkg::SEL_WAIT_NEW: begin
          next_dsm_out = 1'b0;
          if (!cur_clk) begin
            next_sel_state = cdsg_pkg::SEL_RUN;
          end
        end
        default: begin
          next_sel_state = cdsg_pkg::SEL_RUN;
          next_dsm_out = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sel_state <= cdsg_pkg::SEL_RUN;
      sel_cur <= 1'b0;
      dsm_out <= 1'b0;
    end else begin
      sel_state <= next_sel_state;
      sel_cur <= next_sel_cur;
      dsm_out <= next_dsm_out;
    end
  end

  // center mux with one clock gate per trunk
  logic [`CDSG_NSRC-1:0] center_clock_mux_all;
  assign center_clock_mux_all = {samp[`CDSG_B_SRC +: `CDSG_NEXT], dsm_out, edge_out};

  for (genvar t = 0; t < `CDSG_NTRUNK; t++) begin : g_trunk
    logic raw_clk;
    logic en_hold;
    logic next_en_hold;
    logic next_out;
    logic out_q;

    always_comb begin
      raw_clk = center_clock_mux_all[trunk_sel[t*`CDSG_TSEL_W +: `CDSG_TSEL_W]];
      // enable only moves while the clock is low, so no runt pulse
      next_en_hold = raw_clk ? en_hold : trunk_en[t];
      next_out = raw_clk & next_en_hold;
    end

    always_ff @(posedge clk_sys) begin
      if (rst) begin
        en_hold <= 1'b0;
        out_q <= 1'b0;
      end else begin
        en_hold <= next_en_hold;
        out_q <= next_out;
      end
    end

    assign trunk_out[t] = out_q;
  end

  // master delay loop measures the reference period in clk_sys cycles
  logic [`CDSG_PER_W-1:0] per_cnt;
  logic [`CDSG_PER_W-1:0] next_per_cnt;
  logic ref_seen;
  logic next_ref_seen;
  cdsg_pkg::cdsg_dll_s next_dll_status;
  logic [`CDSG_PER_W:0] quarter;
  logic ref_rise;

  always_comb begin
    ref_rise = samp[`CDSG_B_DREF] & ~samp_d[`CDSG_B_DREF];
    quarter = ({1'b0, per_cnt} + 12'h002) >> 2;
    next_per_cnt = (per_cnt == `CDSG_PER_MAX) ? per_cnt : per_cnt + 11'h001;
    next_ref_seen = ref_seen;
    next_dll_status = dll_status;
    if (ref_rise) begin
      next_per_cnt = 11'h001;
      next_ref_seen = 1'b1;
      if (ref_seen) begin
        // long periods clip at the largest code
        next_dll_status.code = (quarter > 12'h1ff) ? `CDSG_CODE_MAX
                                                   : quarter[`CDSG_CODE_W-1:0];
        next_dll_status.valid = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      per_cnt <= '0;
      ref_seen <= 1'b0;
      dll_status <= '0;
    end else begin
      per_cnt <= next_per_cnt;
      ref_seen <= next_ref_seen;
      dll_status <= next_dll_status;
    end
  end

  // slave delays share the one code; code n adds n cycles over the plain path
  logic [`CDSG_DLY_DEPTH-1:0] hist_pin;
  logic [`CDSG_DLY_DEPTH-1:0] hist_strb;
  logic [`CDSG_DLY_DEPTH-1:0] next_hist_pin;
  logic [`CDSG_DLY_DEPTH-1:0] next_hist_strb;
  logic next_slave_clk;
  logic next_strobe;

  always_comb begin
    next_hist_pin = {hist_pin[`CDSG_DLY_DEPTH-2:0], samp[`CDSG_B_EPIN]};
    next_hist_strb = {hist_strb[`CDSG_DLY_DEPTH-2:0], samp[`CDSG_B_STRB]};
    next_slave_clk = next_hist_pin[dll_status.code];
    next_strobe = next_hist_strb[dll_status.code];
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      hist_pin <= '0;
      hist_strb <= '0;
      slave_clk_out <= 1'b0;
      strobe_out <= 1'b0;
    end else begin
      hist_pin <= next_hist_pin;
      hist_strb <= next_hist_strb;
      slave_clk_out <= next_slave_clk;
      strobe_out <= next_strobe;
    end
  end

endmodule : cdsg_top
`default_nettype wire
